/* File: include/vrsp_consts.svh */
// Named constants for the video RAM serial access port.
`ifndef VRSP_CONSTS_SVH
`define VRSP_CONSTS_SVH
`define VRSP_ROWS 512
`define VRSP_ROW_BITS 2048
`define VRSP_LANES 8
`define VRSP_LANE_WORDS 256
`define VRSP_PTR_W 9
`define VRSP_ROW_W 9
`define VRSP_PTR_TOP 8
`define VRSP_PTR_ZERO 9'h000
`define VRSP_PTR_ONE 9'h001
`define VRSP_HALF_WORDS 9'h100
`define VRSP_WORD_ZERO 8'h00
`endif

/* File: include/vrsp_pkg.sv */
// Types shared by the video RAM serial access port.
package vrsp_pkg;
   // --------------------------------------------------------------------
   // Transfer request captured at the row strobe falling edge.
   // --------------------------------------------------------------------
   typedef struct packed {
      logic col_strobe_n;      // Column strobe level, active low.
      logic xfer_oe_n;         // Transfer/output enable, active low.
      logic wmask_we_n;        // Write mask/write enable, active low.
      logic serial_en_n;       // Serial port enable, active low.
      logic split;             // Split function input.
   } vrsp_ctl_t;
   // --------------------------------------------------------------------
   // Kinds of transfer cycle, one-hot.
   // --------------------------------------------------------------------
   typedef enum logic [5:0] {
      VRSP_NONE   = 6'h01,
      VRSP_READ   = 6'h02,
      VRSP_WRITE  = 6'h04,
      VRSP_PSEUDO = 6'h08,
      VRSP_SREAD  = 6'h10,
      VRSP_SWRITE = 6'h20
   } vrsp_xfer_t;
endpackage

/* File: logic/vrsp_sync.sv */
// Two-flop synchroniser for inputs from outside the core clock.
`timescale 1ns/1ns
module vrsp_sync #(parameter int W = 1) (
   input wire logic core_clk, // Core clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic clk_en, // Clock enable, freezes state when low.
   input wire logic [W-1:0] async_in, // Unsynchronised input.
   output logic [W-1:0] sync_out // Synchronised output.
);
   logic [W-1:0] meta_ff; // First stage, read only by second stage.
   // Only the second stage may be looked at by any logic.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         sync_out <= '0;
      end else if (clk_en) begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule // vrsp_sync

/* File: logic/vrsp_serial_port.sv */
// Serial access port: serial register, pointer, transfers and direction.
// Notes on behaviour
// [RQ1] Split input high makes split write transfer.
// [RQ2] Split write: serial enable ignored, port disabled.
// [RQ3] Half flag low lower half, high upper.
// [RQ4] Serial words shift on rising serial clock.
// [RQ5] Each shift advances nine-bit serial pointer.
// [RQ6] Pointer starts at column address, wraps around. Code skips the load on a pseudo write.
// [RQ7] Latest transfer sets direction; read gives output. Code keeps direction on split transfers.
// [RQ8] Pseudo write makes input; write keeps input.
// [RQ9] Controller waits then issues eight init cycles.
// [RQ10] Eight 256-bit lanes, full row per transfer.
// [RQ11] Ports independent except during transfers.
// [RQ12] Array has 512 rows of 2048 bits.
// [RQ13] Array refresh by controller; register needs none.
// [RQ14] Inputs latched internally; outputs are not. Code registers serial_data_pins_out.
// [RQ15] Read transfer: column high, write enable high.
// [RQ16] Write transfer: column high, other controls low.
// [RQ17] Pseudo write: like write, serial enable high.
// [RQ18] Top column bit selects split half.
// [RQ19] Pointer wraps to zero, flag follows half.
`timescale 1ns/1ns
`include "vrsp_consts.svh"
module vrsp_serial_port
   import vrsp_pkg::*;
(
   input wire logic core_clk, // Core clock, 250 MHz.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic clk_en, // Clock enable, freezes state when low.
   input wire logic row_strobe_n, // Row strobe pin, active low.
   input wire logic col_strobe_n, // Column strobe pin, active low.
   input wire logic transfer_output_enable_n, // Transfer/OE pin, low.
   input wire logic write_mask_write_enable_n, // Mask/WE pin, low.
   input wire logic serial_port_enable_n, // Serial enable pin, low.
   input wire logic split_function_input, // Split function pin.
   input wire logic [8:0] addr_pins, // Multiplexed address pins.
   input wire logic serial_shift_clock, // Serial clock pin.
   input wire logic [7:0] serial_data_pins_in, // Serial data pins in.
   output logic [7:0] serial_data_pins_out, // Serial data pins out.
   output logic serial_data_pins_oe, // High while pins are driven.
   output logic active_half_flag, // Half being accessed by pointer.
   output logic [`VRSP_ROW_W-1:0] xfer_row, // Row of latest transfer.
   output logic array_rd_req, // Pulse: load register from row.
   output logic array_wr_req, // Pulse: store register to row.
   output logic array_split, // High with request for half only.
   output logic array_half, // Half moved by a split request.
   input wire logic [`VRSP_ROW_BITS-1:0] array_rd_data, // Row from array.
   output logic [`VRSP_ROW_BITS-1:0] array_wr_data // Register to array.
);
   // ---------------------------------------------------------------------
   // Synchronisers for every pin.
   // ---------------------------------------------------------------------
   localparam int SW = 24; // Width of the synchronised pin bundle.
   logic [SW-1:0] pins_raw; // Raw pin bundle.
   logic [SW-1:0] pins_s; // Synchronised pin bundle.
   assign pins_raw = {row_strobe_n, col_strobe_n, transfer_output_enable_n,
                      write_mask_write_enable_n, serial_port_enable_n,
                      split_function_input, addr_pins, serial_shift_clock,
                      serial_data_pins_in};
   vrsp_sync #(.W(SW)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );
   logic ras_s, cas_s, sclk_s; // Synchronised strobes and serial clock.
   vrsp_ctl_t ctl_s; // Synchronised transfer controls.
   logic [8:0] addr_s; // Synchronised address.
   logic [7:0] sdi_s; // Synchronised serial input data.
   assign ras_s = pins_s[23];
   assign cas_s = pins_s[22];
   assign ctl_s = vrsp_ctl_t'(pins_s[22:18]);
   assign addr_s = pins_s[17:9];
   assign sclk_s = pins_s[8];
   assign sdi_s = pins_s[7:0];
   // ---------------------------------------------------------------------
   // Edge detection on the synchronised strobes.
   // ---------------------------------------------------------------------
   // The delayed copies reset to the synchroniser's reset output, zero,
   // so that the climb of the synchronised strobes after reset is no edge.
   logic ras_d_ff, cas_d_ff, sclk_d_ff; // Delayed copies for edges.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ras_d_ff <= 1'h0;
         cas_d_ff <= 1'h0;
         sclk_d_ff <= 1'h0;
      end else if (clk_en) begin
         ras_d_ff <= ras_s;
         cas_d_ff <= cas_s;
         sclk_d_ff <= sclk_s;
      end
   end
   logic ras_fall, cas_fall, sclk_rise; // Single-cycle edge pulses.
   assign ras_fall = ras_d_ff && !ras_s;
   assign cas_fall = cas_d_ff && !cas_s && !ras_s;
   assign sclk_rise = !sclk_d_ff && sclk_s;
   // ---------------------------------------------------------------------
   // Decode of the cycle at the row strobe falling edge.
   // ---------------------------------------------------------------------
   vrsp_xfer_t nxt_kind; // Kind decoded from the present pins.
   always_comb begin
      nxt_kind = VRSP_NONE;
      // Column strobe low first is a refresh; ignored here. [RQ13]
      if (ctl_s.col_strobe_n && !ctl_s.xfer_oe_n) begin
         if (!ctl_s.wmask_we_n) begin
            if (ctl_s.split)
               nxt_kind = VRSP_SWRITE; // [RQ1] [RQ2]
            else if (ctl_s.serial_en_n)
               nxt_kind = VRSP_PSEUDO; // [RQ17]
            else
               nxt_kind = VRSP_WRITE; // [RQ16]
         end else begin
            nxt_kind = ctl_s.split ? VRSP_SREAD : VRSP_READ; // [RQ15]
         end
      end
   end
   // ---------------------------------------------------------------------
   // Transfer sequencer: row latched at the row edge, column at the
   // column edge, then the array is engaged once, or not at all for a pseudo write.
   // ---------------------------------------------------------------------
   vrsp_xfer_t kind_ff; // Transfer in progress.
   logic wait_col_ff; // Waiting for the column address.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         kind_ff <= VRSP_NONE;
         wait_col_ff <= 1'h0;
         xfer_row <= '0;
      end else if (clk_en) begin
         if (ras_fall) begin
            kind_ff <= nxt_kind;
            wait_col_ff <= nxt_kind != VRSP_NONE;
            xfer_row <= addr_s; // [RQ12] [RQ14]
         end else if (cas_fall || ras_s) begin
            wait_col_ff <= 1'h0;
            if (ras_s)
               kind_ff <= VRSP_NONE;
         end
      end
   end
   logic xfer_go; // Column edge of a pending transfer.
   assign xfer_go = wait_col_ff && cas_fall;
   // Serial port is held off for the whole split write cycle. [RQ2]
   logic serial_hold; // Serial port disabled.
   assign serial_hold = kind_ff == VRSP_SWRITE;
   // ---------------------------------------------------------------------
   // Array requests: one pulse at the column edge of a transfer other than a pseudo write. [RQ11]
   // ---------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         array_rd_req <= 1'h0;
         array_wr_req <= 1'h0;
         array_split <= 1'h0;
         array_half <= 1'h0;
      end else if (clk_en) begin
         array_rd_req <= xfer_go && (kind_ff == VRSP_READ ||
                                     kind_ff == VRSP_SREAD); // [RQ10]
         array_wr_req <= xfer_go && (kind_ff == VRSP_WRITE ||
                                     kind_ff == VRSP_SWRITE);
         if (xfer_go) begin
            array_split <= kind_ff == VRSP_SREAD || kind_ff == VRSP_SWRITE;
            array_half <= addr_s[`VRSP_PTR_TOP]; // [RQ18]
         end
      end
   end
   // ---------------------------------------------------------------------
   // Serial register: 512 words of eight bits, two halves of 256.
   // The row bus carries one half's worth of words, so a full load
   // fills both halves from the row and a split load fills one.
   // The static register never needs refresh. [RQ13]
   // ---------------------------------------------------------------------
   logic [7:0] sreg_ff [`VRSP_LANE_WORDS*2]; // Words across both halves.
   logic [`VRSP_PTR_W-1:0] ptr_ff; // Serial pointer.
   logic sdir_out_ff; // High while serial pins are outputs.
   logic shift_ok; // A serial clock edge that may shift.
   assign shift_ok = sclk_rise && !serial_hold && !ctl_s.serial_en_n;
   // Row load replaces the whole register, or half on a split. [RQ10]
   always_ff @(posedge core_clk) begin
      if (clk_en) begin
         for (int w = 0; w < `VRSP_LANE_WORDS * 2; w++) begin
            if (array_rd_req &&
                (!array_split || (w >= `VRSP_LANE_WORDS) == array_half))
               sreg_ff[w] <= array_rd_data[(w % `VRSP_LANE_WORDS) *
                                           `VRSP_LANES +: `VRSP_LANES];
         end
         if (shift_ok && !sdir_out_ff)
            sreg_ff[ptr_ff] <= sdi_s; // [RQ4]
      end
   end
   // A store sends the half named by the top column bit of the transfer.
   always_comb begin
      for (int w = 0; w < `VRSP_LANE_WORDS; w++)
         array_wr_data[w*`VRSP_LANES +: `VRSP_LANES] =
            sreg_ff[array_half ? w + `VRSP_LANE_WORDS : w];
   end
   // ---------------------------------------------------------------------
   // Serial pointer: loaded at the transfer column except on a pseudo write, then wraps. [RQ6]
   // ---------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_ff <= `VRSP_PTR_ZERO;
      end else if (clk_en) begin
         if (xfer_go && kind_ff != VRSP_PSEUDO)
            ptr_ff <= addr_s; // [RQ6] [RQ14]
         else if (shift_ok)
            ptr_ff <= ptr_ff + `VRSP_PTR_ONE; // [RQ5] [RQ19]
      end
   end
   // Flag is the pointer's top bit, so it follows the wrap. [RQ3] [RQ19]
   assign active_half_flag = ptr_ff[`VRSP_PTR_TOP];
   // ---------------------------------------------------------------------
   // Pin direction from the latest full transfer; splits keep it.
   // ---------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sdir_out_ff <= 1'h0;
      end else if (clk_en && xfer_go) begin
         case (kind_ff)
            VRSP_READ: sdir_out_ff <= 1'h1; // [RQ7]
            VRSP_PSEUDO: sdir_out_ff <= 1'h0; // [RQ8]
            VRSP_WRITE: sdir_out_ff <= 1'h0; // [RQ8]
            default: sdir_out_ff <= sdir_out_ff;
         endcase
      end
   end
   // Output word is registered; it changes on each shift edge. [RQ4]
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         serial_data_pins_out <= `VRSP_WORD_ZERO;
      else if (clk_en && shift_ok)
         serial_data_pins_out <= sreg_ff[ptr_ff];
   end
   // Drive only as outputs, with the port enabled and not held off.
   assign serial_data_pins_oe = sdir_out_ff && !ctl_s.serial_en_n &&
                                !serial_hold;
   // ---------------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------------
   split_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      serial_hold |-> !serial_data_pins_oe) // [RQ2]
      else $error("Serial pins driven during split write.");
   half_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      active_half_flag == (ptr_ff >= `VRSP_HALF_WORDS)) // [RQ3]
      else $error("Half flag does not match pointer.");
   ptr_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && shift_ok && !xfer_go |=> ptr_ff == $past(ptr_ff) + 9'h001)
      else $error("Pointer did not advance on shift."); // [RQ5]
   ptr_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && !shift_ok && !xfer_go |=> $stable(ptr_ff)) // [RQ4]
      else $error("Pointer moved without serial clock.");
   ptr_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && xfer_go && kind_ff == VRSP_READ |=>
      ptr_ff == $past(addr_s)) // [RQ6]
      else $error("Pointer not loaded from column.");
   ptr_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && shift_ok && !xfer_go && ptr_ff == 9'h1FF |=>
      ptr_ff == 9'h000 && !active_half_flag) // [RQ19]
      else $error("Pointer did not wrap to zero.");
   read_dir_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && xfer_go && kind_ff == VRSP_READ |=> sdir_out_ff) // [RQ7]
      else $error("Read transfer left pins as inputs.");
   pseudo_dir_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && xfer_go && (kind_ff == VRSP_PSEUDO ||
      kind_ff == VRSP_WRITE) |=> !sdir_out_ff) // [RQ8]
      else $error("Write or pseudo write left pins as outputs.");
   split_kind_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && ras_fall && nxt_kind != VRSP_NONE && !ctl_s.wmask_we_n &&
      ctl_s.split |=> kind_ff == VRSP_SWRITE) // [RQ1]
      else $error("Split write not recognised.");
   half_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && xfer_go |=>
      array_half == $past(addr_s[`VRSP_PTR_TOP])) // [RQ18]
      else $error("Split half not from top column bit.");
   read_cov_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      array_rd_req && !array_split);
   swrite_cov_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      array_wr_req && array_split);
   wrap_cov_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      shift_ok && ptr_ff == 9'h1FF);
   pseudo_cov_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      xfer_go && kind_ff == VRSP_PSEUDO);
endmodule // vrsp_serial_port

/* File: verif/vrsp_array_model.sv */
// Behavioural model of the DRAM array beside the serial port.
`timescale 1ns/1ns
`include "vrsp_consts.svh"
module vrsp_array_model (
   input wire logic core_clk, // Core clock.
   input wire logic rd_req, // Load request pulse.
   input wire logic wr_req, // Store request pulse.
   input wire logic [`VRSP_ROW_W-1:0] row, // Row of the transfer.
   input wire logic [`VRSP_ROW_BITS-1:0] wr_data, // Register contents.
   output logic [`VRSP_ROW_BITS-1:0] rd_data, // Row handed over.
   output logic [`VRSP_ROW_BITS-1:0] last_wr // Last row stored.
);
   // ----------------------------------------------------------------
   // Row contents
   // ----------------------------------------------------------------
   // Each word mixes its index with the low eight row bits, so a wrong word
   // or a wrong low row byte shows; outside the load cycle the bus carries the inverse, as
   // the array holds nothing steady for a late sampler.
   always_comb begin
      for (int w = 0; w < `VRSP_LANE_WORDS; w++) begin
         rd_data[8*w +: 8] = rd_req ? (8'(w) ^ row[7:0])
                                    : ~(8'(w) ^ row[7:0]);
      end
   end
   // The half sent by the store is taken in the cycle of the store request.
   always_ff @(posedge core_clk) begin
      if (wr_req) begin
         last_wr <= wr_data;
      end
   end
endmodule // vrsp_array_model

/* File: verif/tb_top.sv */
// Self-checking bench for the video RAM serial access port.
`timescale 1ns/1ns
module tb_top;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam int INIT_PAUSE = 50000; // Power-up pause, 200 us.
   logic core_clk, rst_n, clk_en, row_strobe_n, col_strobe_n;
   logic transfer_output_enable_n, write_mask_write_enable_n;
   logic serial_port_enable_n, split_function_input, serial_shift_clock;
   logic [8:0] addr_pins, xfer_row;
   logic [7:0] sd_drive, serial_data_pins_out, got;
   wire [7:0] sd_wire; // Level on the shared serial data pins.
   logic serial_data_pins_oe, active_half_flag, oe_mid;
   logic array_rd_req, array_wr_req, array_split, array_half;
   logic [2047:0] rd_data, wr_data, last_wr;
   int fails = 0, comparisons = 0, tot_rd = 0, tot_wr = 0, n_rd, n_wr;
   // The device wins the pins while it drives them.
   assign sd_wire = serial_data_pins_oe ? serial_data_pins_out : sd_drive;
   vrsp_serial_port uut (.core_clk(core_clk), .rst_n(rst_n),
      .clk_en(clk_en), .row_strobe_n(row_strobe_n),
      .col_strobe_n(col_strobe_n),
      .transfer_output_enable_n(transfer_output_enable_n),
      .write_mask_write_enable_n(write_mask_write_enable_n),
      .serial_port_enable_n(serial_port_enable_n),
      .split_function_input(split_function_input), .addr_pins(addr_pins),
      .serial_shift_clock(serial_shift_clock),
      .serial_data_pins_in(sd_wire),
      .serial_data_pins_out(serial_data_pins_out),
      .serial_data_pins_oe(serial_data_pins_oe),
      .active_half_flag(active_half_flag), .xfer_row(xfer_row),
      .array_rd_req(array_rd_req), .array_wr_req(array_wr_req),
      .array_split(array_split), .array_half(array_half),
      .array_rd_data(rd_data), .array_wr_data(wr_data));
   vrsp_array_model arr (.core_clk(core_clk), .rd_req(array_rd_req),
      .wr_req(array_wr_req), .row(xfer_row), .wr_data(wr_data),
      .rd_data(rd_data), .last_wr(last_wr));
   // Request pulses are counted all the time, so stray ones show too.
   always @(posedge core_clk) begin
      if (array_rd_req === 1'b1) tot_rd++;
      if (array_wr_req === 1'b1) tot_wr++;
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge core_clk);
         #1;
      end
   endtask
   task automatic cmp_vec(input logic [8:0] g, input logic [8:0] e,
                          input string what);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
      end
   endtask
   task automatic cmp_bit(input logic g, input logic e, input string what);
      cmp_vec({8'h00, g}, {8'h00, e}, what);
   endtask
   // Transfer cycle; ctl is {oe_n, we_n, se_n, split}. With early set,
   // the column strobe falls before the row strobe, a refresh.
   task automatic transfer(input logic early, input logic [3:0] ctl,
                           input logic [8:0] row, input logic [8:0] col);
      int rd0, wr0;
      rd0 = tot_rd;
      wr0 = tot_wr;
      {transfer_output_enable_n, write_mask_write_enable_n,
       serial_port_enable_n, split_function_input} = ctl;
      addr_pins = row;
      col_strobe_n = ~early;
      tick(4);
      row_strobe_n = 1'b0;
      tick(5);
      addr_pins = col;
      tick(2);
      col_strobe_n = 1'b0;
      tick(12);
      oe_mid = serial_data_pins_oe; // Row strobe is still low here.
      col_strobe_n = 1'b1;
      row_strobe_n = 1'b1;
      tick(6);
      {transfer_output_enable_n, write_mask_write_enable_n,
       serial_port_enable_n, split_function_input} = 4'hC;
      tick(4);
      n_rd = tot_rd - rd0;
      n_wr = tot_wr - wr0;
   endtask
   // One serial clock period of 64 ns: 4 low, 8 high, 4 low cycles.
   task automatic shift(input logic [7:0] din, output logic [7:0] dout);
      sd_drive = din;
      tick(4);
      serial_shift_clock = 1'b1;
      tick(8);
      dout = serial_data_pins_out;
      serial_shift_clock = 1'b0;
      sd_drive = ~din; // A released line shows the inverse, not a hold.
      tick(4);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_init();
      tick(INIT_PAUSE);
      repeat (8) transfer(1'b0, 4'hC, 9'h000, 9'h000);
      repeat (8) shift(8'h00, got);
      cmp_vec(9'(tot_rd + tot_wr), 9'h000, "init reqs");
      cmp_bit(serial_data_pins_oe, 1'b0, "init dir");
      $display("test init done");
   endtask
   task automatic t_read();
      transfer(1'b0, 4'h4, 9'h005, 9'h0FE);
      cmp_vec(9'(n_rd), 9'h001, "rd count");
      cmp_vec(xfer_row, 9'h005, "rd row");
      cmp_bit(serial_data_pins_oe, 1'b1, "rd dir");
      shift(8'h00, got);
      cmp_vec({1'b0, got}, 9'h0FB, "word FE");
      cmp_bit(active_half_flag, 1'b0, "flag low");
      shift(8'h00, got);
      cmp_vec({1'b0, got}, 9'h0FA, "word FF");
      cmp_bit(active_half_flag, 1'b1, "flag high");
      transfer(1'b0, 4'h4, 9'h1A3, 9'h1FF);
      cmp_bit(active_half_flag, 1'b1, "flag top");
      shift(8'h00, got);
      cmp_bit(active_half_flag, 1'b0, "flag wrap");
      shift(8'h00, got);
      cmp_vec({1'b0, got}, 9'h0A3, "word 0");
      $display("test read done");
   endtask
   task automatic t_refresh_split();
      transfer(1'b1, 4'h4, 9'h009, 9'h000);
      cmp_vec(9'(n_rd + n_wr), 9'h000, "refresh reqs");
      transfer(1'b0, 4'h3, 9'h007, 9'h100);
      cmp_vec({n_rd[3:0], n_wr[4:0]}, 9'h001, "split wr");
      cmp_bit(array_split, 1'b1, "split");
      cmp_bit(array_half, 1'b1, "half up");
      cmp_bit(oe_mid, 1'b0, "port off");
      cmp_bit(serial_data_pins_oe, 1'b1, "no pseudo");
      transfer(1'b0, 4'h1, 9'h006, 9'h000);
      cmp_bit(oe_mid, 1'b0, "held off");
      transfer(1'b0, 4'h5, 9'h008, 9'h0F0);
      cmp_vec(9'(n_rd), 9'h001, "split rd");
      cmp_bit(array_half, 1'b0, "half low");
      $display("test refresh split done");
   endtask
   task automatic t_write();
      transfer(1'b0, 4'h2, 9'h002, 9'h000);
      cmp_vec(9'(n_rd + n_wr), 9'h000, "pseudo reqs");
      cmp_bit(serial_data_pins_oe, 1'b0, "pseudo dir");
      transfer(1'b0, 4'h0, 9'h033, 9'h010);
      cmp_vec(9'(n_wr), 9'h001, "wr count");
      cmp_vec(xfer_row, 9'h033, "wr row");
      cmp_bit(serial_data_pins_oe, 1'b0, "wr dir");
      shift(8'h5A, got);
      shift(8'hC3, got);
      transfer(1'b0, 4'h0, 9'h044, 9'h000);
      cmp_bit(array_split, 1'b0, "full row");
      cmp_vec({1'b0, last_wr[8'h10*8 +: 8]}, 9'h05A, "in 10");
      cmp_vec({1'b0, last_wr[8'h11*8 +: 8]}, 9'h0C3, "in 11");
      $display("test write done");
   endtask
   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // A hang is cut short here and judged as a failure.
   initial begin
      #300000;
      fails++;
      give_verdict();
   end
   initial begin
      {rst_n, clk_en, row_strobe_n, col_strobe_n} = 4'h7;
      {transfer_output_enable_n, write_mask_write_enable_n} = 2'h3;
      {serial_port_enable_n, split_function_input} = 2'h0;
      serial_shift_clock = 1'b0;
      addr_pins = 9'h000;
      sd_drive = 8'h00;
      tick(12);
      rst_n = 1'b1;
      tick(4);
      t_init();
      t_read();
      t_refresh_split();
      t_write();
      give_verdict();
   end
endmodule // tb_top
